// ===== rtl/fle_pkg.sv
// Shared constants, types and Galois-field helpers for the link error-correction block.
// Assumes a 10-bit symbol stream and a register bus with 8-bit byte addresses.
package fle_pkg;

  // Code geometry
  localparam int FLE_SYM_W = 10;
  localparam int FLE_CW_N = 254;
  localparam int FLE_DATA_N = 250;
  localparam int FLE_PAR_N = FLE_CW_N - FLE_DATA_N;
  localparam logic [10:0] FLE_GF_POLY = 11'h409;
  localparam logic [9:0] FLE_GF_ALPHA = 10'h002;

  // Sink configuration write that announces decode capability
  localparam logic [19:0] FLE_SINK_CFG_ADDR = 20'h00120;
  localparam logic [7:0] FLE_SINK_CFG_READY = 8'h01;

  // Register offsets and reset values
  localparam logic [7:0] FLE_REG_CTRL = 8'h00;
  localparam logic [7:0] FLE_REG_STAT = 8'h04;
  localparam logic [7:0] FLE_CTRL_RST = 8'h00;
  localparam logic [1:0] FLE_PSR_V2 = 2'h2;

  // Control register layout, bit 0 upward: req, dsc, edp, mst, psr, lanes
  typedef struct packed {
    logic [1:0] lanes;
    logic [1:0] psr;
    logic mst;
    logic edp;
    logic dsc;
    logic req;
  } fle_ctrl_t;

  // Outgoing link symbol with its parity mark
  typedef struct packed {
    logic parity;
    logic [FLE_SYM_W-1:0] data;
  } fle_sym_t;

  // Enable handshake states
  typedef enum logic [4:0] {
    FLE_IDLE = 5'h01,
    FLE_ANNOUNCE = 5'h02,
    FLE_TRAIN = 5'h04,
    FLE_START = 5'h08,
    FLE_ENC = 5'h10
  } fle_state_t;

  // Multiply in GF(2^10)
  function automatic logic [9:0] fle_gf_mul(input logic [9:0] a, input logic [9:0] b);
    logic [9:0] acc;
    logic [9:0] sh;
    acc = 10'h000;
    sh = a;
    for (int i = 0; i < 10; i++) begin
      if (b[i]) acc = acc ^ sh;
      sh = sh[9] ? ((sh << 1) ^ FLE_GF_POLY[9:0]) : (sh << 1);
    end
    return acc;
  endfunction : fle_gf_mul

  // Generator polynomial coefficients g0..g3, leading one implied
  function automatic logic [3:0][9:0] fle_gen_poly();
    logic [4:0][9:0] c;
    logic [9:0] r;
    c = '0;
    c[0] = 10'h001;
    r = 10'h001;
    for (int i = 0; i < 4; i++) begin
      for (int j = 4; j > 0; j--) begin
        c[j] = c[j-1] ^ fle_gf_mul(c[j], r);
      end
      c[0] = fle_gf_mul(c[0], r);
      r = fle_gf_mul(r, FLE_GF_ALPHA);
    end
    return c[3:0];
  endfunction : fle_gen_poly

endpackage : fle_pkg

// ===== rtl/fle_rs_enc.sv
// Systematic Reed-Solomon encoder: passes data, then appends parity symbols.
// Assumes the mode input changes only through the control FSM; mode is taken at codeword start.
`timescale 1ns/1ps
`default_nettype none
module fle_rs_enc #(
  parameter int DATA_N = fle_pkg::FLE_DATA_N,
  parameter int PAR_N = fle_pkg::FLE_PAR_N
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Mode
  input wire logic enc_en,
  output logic enc_active,
  // Input stream
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [fle_pkg::FLE_SYM_W-1:0] in_data,
  // Output stream
  output logic out_valid,
  input wire logic out_ready,
  output fle_pkg::fle_sym_t out_sym
);
  import fle_pkg::*;

  localparam logic [3:0][9:0] GEN = fle_gen_poly();
  localparam int CW = $clog2(DATA_N + 1);
  localparam int PW = $clog2(PAR_N + 1);

  logic [3:0][9:0] par_q, par_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [PW-1:0] pcnt_q, pcnt_d;
  logic mode_q, mode_d;
  logic ov_q, ov_d;
  fle_sym_t os_q, os_d;
  logic free, in_par, take;
  logic [9:0] fb;

  // Handshake terms
  assign free = !ov_q || out_ready;
  assign in_par = mode_q && (cnt_q == CW'(DATA_N));
  assign in_ready = free && !in_par;
  assign take = in_valid && in_ready;
  assign fb = in_data ^ par_q[3];

  // Next state of the codeword engine
  always_comb begin
    par_d = par_q;
    cnt_d = cnt_q;
    pcnt_d = pcnt_q;
    mode_d = mode_q;
    ov_d = ov_q && !out_ready;
    os_d = os_q;
    if (cnt_q == '0 && pcnt_q == '0) mode_d = enc_en;
    if (free && in_par) begin
      os_d = '{parity: 1'b1, data: par_q[3]};
      ov_d = 1'b1;
      par_d = {par_q[2:0], 10'h000};
      if (pcnt_q == PW'(PAR_N - 1)) begin
        pcnt_d = '0;
        cnt_d = '0;
      end else begin
        pcnt_d = pcnt_q + PW'(1);
      end
    end else if (take) begin
      os_d = '{parity: 1'b0, data: in_data};
      ov_d = 1'b1;
      // A symbol taken at a codeword start follows the freshly latched mode,
      // so the mode and the codeword count never disagree
      if (mode_d) begin
        // Parity LFSR over the generator polynomial
        par_d[3] = par_q[2] ^ fle_gf_mul(fb, GEN[3]);
        par_d[2] = par_q[1] ^ fle_gf_mul(fb, GEN[2]);
        par_d[1] = par_q[0] ^ fle_gf_mul(fb, GEN[1]);
        par_d[0] = fle_gf_mul(fb, GEN[0]);
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      par_q <= '0;
      cnt_q <= '0;
      pcnt_q <= '0;
      mode_q <= 1'b0;
      ov_q <= 1'b0;
      os_q <= '0;
    end else begin
      par_q <= par_d;
      cnt_q <= cnt_d;
      pcnt_q <= pcnt_d;
      mode_q <= mode_d;
      ov_q <= ov_d;
      os_q <= os_d;
    end
  end

  assign out_valid = ov_q;
  assign out_sym = os_q;
  assign enc_active = mode_q;

  // Parity only ever leaves in coded mode, after a full data run
  a_parity_placed: assert property (@(posedge clk) disable iff (!rst_n)
    (ov_q && out_ready && os_q.parity) |-> (mode_q && cnt_q == CW'(DATA_N)) || (cnt_q == '0 && pcnt_q == '0))
    else $error("parity symbol outside codeword tail");
  // No data accepted while parity drains
  a_no_data_in_tail: assert property (@(posedge clk) disable iff (!rst_n)
    in_par |-> !in_ready)
    else $error("data accepted during parity phase");

endmodule : fle_rs_enc
`default_nettype wire

// ===== rtl/fle_fec_link.sv
// Link error-correction block: Wishbone registers, enable handshake FSM, encoder instance.
// Assumes link training, sideband writes and the symbol stream all run on clk.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Encode with RS codewords of 254 ten-bit symbols, 250 of them data.
// - Write 1 to sink config 00120h bit 0 before starting link training.
// - Emit no encoded symbols until link training has fully finished.
// - After training, send the decode-start sequence where encoded data begins.
// - Compression may run only while error correction runs on the link.
// - Correction works for single and multi stream, at every lane count.
// - Embedded links allow correction without or with self-refresh v1, never v2.
module fle_fec_link (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sideband write toward the sink
  output logic aux_wr_req,
  output logic [19:0] aux_wr_addr,
  output logic [7:0] aux_wr_data,
  input wire logic aux_wr_done,
  // Link training
  output logic train_allow,
  input wire logic train_done,
  // Decode-start sequence
  output logic decode_start_sequence,
  input wire logic decode_start_sent,
  // Compression gate
  output logic dsc_allow,
  // Symbol stream
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [fle_pkg::FLE_SYM_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output fle_pkg::fle_sym_t out_sym
);
  import fle_pkg::*;

  fle_ctrl_t ctrl_q, ctrl_d;
  logic ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  fle_state_t st_q, st_d;
  logic cfg_bad, enc_go, enc_active, bus_req;

  // Self-refresh v2 on an embedded link forbids correction
  assign cfg_bad = ctrl_q.edp && (ctrl_q.psr == FLE_PSR_V2);
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;

  // Bus next state: one-cycle ack, byte lane 0 holds control
  always_comb begin
    ctrl_d = ctrl_q;
    ack_d = bus_req;
    rd_d = rd_q;
    if (bus_req) begin
      rd_d = 32'h0000_0000;
      if (wb_we_i && wb_adr_i == FLE_REG_CTRL && wb_sel_i[0]) begin
        ctrl_d = wb_dat_i[7:0];
      end
      if (!wb_we_i) begin
        case (wb_adr_i)
          FLE_REG_CTRL: rd_d = {24'h00_0000, ctrl_q};
          FLE_REG_STAT: rd_d = {21'h00_0000, !dsc_allow && ctrl_q.dsc, cfg_bad, enc_active,
                                train_done, 2'h0, st_q};
          default: rd_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // Bus registers; correction request starts cleared
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= FLE_CTRL_RST;
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      ack_q <= ack_d;
      rd_q <= rd_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;

  // Handshake FSM next state; stream mode and lane count do not gate it
  always_comb begin
    st_d = st_q;
    case (st_q)
      FLE_IDLE: begin
        if (ctrl_q.req && !cfg_bad) st_d = FLE_ANNOUNCE;
      end
      FLE_ANNOUNCE: begin
        if (aux_wr_done) st_d = FLE_TRAIN;
      end
      FLE_TRAIN: begin
        if (train_done) st_d = FLE_START;
      end
      FLE_START: begin
        if (decode_start_sent) st_d = FLE_ENC;
      end
      FLE_ENC: begin
        if (!train_done) st_d = FLE_TRAIN;
      end
      default: st_d = FLE_IDLE;
    endcase
    if (!ctrl_q.req || cfg_bad) st_d = FLE_IDLE;
  end

  // FSM register
  always_ff @(posedge clk) begin
    if (!rst_n) st_q <= FLE_IDLE;
    else st_q <= st_d;
  end

  // Handshake outputs
  assign aux_wr_req = (st_q == FLE_ANNOUNCE);
  assign aux_wr_addr = FLE_SINK_CFG_ADDR;
  assign aux_wr_data = FLE_SINK_CFG_READY;
  assign train_allow = (st_q == FLE_TRAIN) || (st_q == FLE_IDLE && !ctrl_q.req);
  assign decode_start_sequence = (st_q == FLE_START);
  assign enc_go = (st_q == FLE_ENC);
  assign dsc_allow = ctrl_q.dsc && enc_active && enc_go;

  // Encoder
  fle_rs_enc #(
    .DATA_N(FLE_DATA_N),
    .PAR_N(FLE_PAR_N)
  ) u_enc (
    .clk(clk),
    .rst_n(rst_n),
    .enc_en(enc_go),
    .enc_active(enc_active),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_sym(out_sym)
  );

  // Training may not start while the announce is still pending
  a_announce_first: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == FLE_ANNOUNCE) |-> !train_allow)
    else $error("training allowed before announce write");
  // Announce leads to training only on write completion
  a_announce_done: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == FLE_ANNOUNCE && ctrl_q.req && !cfg_bad && aux_wr_done) |=> st_q == FLE_TRAIN)
    else $error("announce did not move to training");
  // Coded mode only after training done and start sequence
  a_enc_after_train: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(enc_go) |-> $past(decode_start_sequence) && $past(train_done))
    else $error("encoding began without training and start sequence");
  // Start sequence held until sent, then encoding next cycle
  a_start_seq: assert property (@(posedge clk) disable iff (!rst_n)
    (decode_start_sequence && decode_start_sent && ctrl_q.req && !cfg_bad) |=> enc_go)
    else $error("start sequence not followed by encoding");
  // Compression never allowed without correction
  a_dsc_needs_fec: assert property (@(posedge clk) disable iff (!rst_n)
    dsc_allow |-> enc_go && enc_active)
    else $error("compression allowed without correction");
  // Request honoured in any stream mode and lane count
  a_any_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == FLE_IDLE && ctrl_q.req && !cfg_bad) |=> st_q == FLE_ANNOUNCE)
    else $error("valid request not acted on");
  // Self-refresh v2 on embedded link keeps the block idle
  a_no_psr2: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_bad |=> st_q == FLE_IDLE && !enc_go)
    else $error("correction active with self-refresh v2");
  // Without a request nothing is announced or started
  a_off_without_req: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_q.req |=> !aux_wr_req && !decode_start_sequence && !enc_go)
    else $error("handshake active without request");
  // Ack is a single-cycle pulse
  a_ack_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule : fle_fec_link
`default_nettype wire

// ===== bench/fle_sink_model.sv
// Sink receiver model: answers the sideband write, trains, sees the start sequence.
// Assumes the block's clock; slow stretches every answer, stall holds back the symbols.
`timescale 1ns/1ps
`default_nettype none
module fle_sink_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Handshake
  input wire logic aux_wr_req,
  input wire logic [19:0] aux_wr_addr,
  input wire logic [7:0] aux_wr_data,
  output logic aux_wr_done,
  input wire logic train_allow,
  output logic train_done,
  input wire logic decode_start_sequence,
  output logic decode_start_sent,
  // Symbols
  input wire logic out_valid,
  output logic out_ready,
  input wire fle_pkg::fle_sym_t out_sym,
  // Bench side
  input wire logic slow,
  input wire logic stall,
  output logic decoding,
  output logic early_sym
);
  import fle_pkg::*;
  logic [3:0] wait_q;
  logic cfg_q;
  wire go = wait_q == (slow ? 4'h9 : 4'h1);
  assign out_ready = !stall;
  // Answer delay, restarted by every completed step
  always_ff @(posedge clk) begin
    if (!rst_n || aux_wr_done || !(aux_wr_req || (train_allow && cfg_q && !train_done) || decode_start_sequence)) begin
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
  // Sink state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {aux_wr_done, cfg_q, train_done, decode_start_sent, decoding, early_sym} <= 6'h00;
    end else begin
      // A new announce starts a fresh training and decode session
      if (aux_wr_req) {train_done, decoding} <= 2'b00;
      aux_wr_done <= aux_wr_req && go && !aux_wr_done;
      if (aux_wr_req && go && aux_wr_addr == FLE_SINK_CFG_ADDR && aux_wr_data[0]) cfg_q <= 1'b1;
      if (train_allow && cfg_q && go) train_done <= 1'b1;
      decode_start_sent <= decode_start_sequence && go && !decode_start_sent;
      if (decode_start_sequence && go) decoding <= 1'b1;
      if (out_valid && out_ready && out_sym.parity && !decoding) early_sym <= 1'b1;
    end
  end
endmodule : fle_sink_model
`default_nettype wire

// ===== bench/fle_fec_link_tb.sv
// Self-checking bench for the link error-correction block.
// Assumes the sink model is compiled first; one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module fle_fec_link_tb;
  import fle_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, in_valid = 1'b0, slow = 1'b0, stall = 1'b0, stall_en = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
  logic [9:0] in_data = 10'h000;
  logic wb_ack, aux_req, aux_done, tr_allow, tr_done, ds_seq, ds_sent, dsc_allow, in_ready, out_valid, out_ready;
  logic decoding, early_sym;
  logic [19:0] aux_addr;
  logic [7:0] aux_data;
  fle_sym_t out_sym;
  int n_errors = 0, check_count = 0, cycles = 0;
  fle_sym_t got_q[$];
  logic [9:0] exp_q[$];
  logic [7:0] modes [7] = '{8'h01, 8'h09, 8'hc9, 8'h41, 8'h05, 8'hd5, 8'h25};
  fle_fec_link dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .aux_wr_req(aux_req), .aux_wr_addr(aux_addr), .aux_wr_data(aux_data), .aux_wr_done(aux_done),
    .train_allow(tr_allow), .train_done(tr_done), .decode_start_sequence(ds_seq), .decode_start_sent(ds_sent),
    .dsc_allow(dsc_allow), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_sym(out_sym));
  fle_sink_model sink_u (.clk(clk), .rst_n(rst_n), .aux_wr_req(aux_req), .aux_wr_addr(aux_addr),
    .aux_wr_data(aux_data), .aux_wr_done(aux_done), .train_allow(tr_allow), .train_done(tr_done),
    .decode_start_sequence(ds_seq), .decode_start_sent(ds_sent), .out_valid(out_valid), .out_ready(out_ready),
    .out_sym(out_sym), .slow(slow), .stall(stall), .decoding(decoding), .early_sym(early_sym));
  always #2.5 clk = ~clk;
  // Timeout, sink stall pattern and output capture
  always @(posedge clk) begin
    cycles <= cycles + 1;
    stall <= stall_en && (cycles % 8 == 3);
    if (rst_n && out_valid === 1'b1 && out_ready === 1'b1) got_q.push_back(out_sym);
    if (cycles == 30000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // Classic single Wishbone cycle; read data lands in rd
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, we, adr, dat, sel};
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    rd = wb_rdat;
    {wb_cyc, wb_stb} <= 2'b00;
  endtask : wb_xfer
  task automatic wait_state(input logic [4:0] st);
    for (int i = 0; i < 60 && rd[4:0] !== st; i++) wb_xfer(1'b0, FLE_REG_STAT, 32'h0, 4'hf);
    repeat (10) @(posedge clk);
    wb_xfer(1'b0, FLE_REG_STAT, 32'h0, 4'hf);
  endtask : wait_state
  task automatic send(input int n, input logic [9:0] base);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_data <= base + 10'(i);
      exp_q.push_back(base + 10'(i));
      @(posedge clk);
      while (in_ready !== 1'b1) @(posedge clk);
    end
    in_valid <= 1'b0;
    in_data <= ~in_data;
  endtask : send
  // Multiply by the primitive element x of the symbol field
  function automatic logic [9:0] times_x(input logic [9:0] a);
    return {a[8:0], 1'b0} ^ (a[9] ? FLE_GF_POLY[9:0] : 10'h000);
  endfunction : times_x
  // Each coded codeword must vanish at the four generator roots x^0..x^3
  task automatic check_stream(input int n, input bit coded);
    fle_sym_t s;
    logic [3:0][9:0] syn;
    syn = '0;
    for (int i = 0; i < n; i++) begin
      for (int t = 0; t < 400 && got_q.size() == 0; t++) @(posedge clk);
      s = (got_q.size() > 0) ? got_q.pop_front() : 11'h7ff;
      for (int j = 0; j < 4; j++) begin
        for (int m = 0; m < j; m++) syn[j] = times_x(syn[j]);
        syn[j] = syn[j] ^ s.data;
      end
      if (coded && i % 254 >= 250) begin
        check("parity mark", 32'(s.parity), 32'h1);
      end else begin
        check("data mark", 32'(s.parity), 32'h0);
        check("data symbol", 32'(s.data), 32'(exp_q.pop_front()));
      end
      if (coded && i % 254 == 253) begin
        check("codeword roots", 32'({|syn[3], |syn[2], |syn[1], |syn[0]}), 32'h0);
        syn = '0;
      end
    end
  endtask : check_stream
  initial begin : main_seq
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, read-only status, unmapped place, masked write
    wb_xfer(1'b0, FLE_REG_CTRL, 32'h0, 4'hf);
    check("ctrl reset", rd, 32'(FLE_CTRL_RST));
    wb_xfer(1'b1, FLE_REG_STAT, 32'h1f, 4'hf);
    wb_xfer(1'b0, FLE_REG_STAT, 32'h0, 4'hf);
    check("stat reset", rd, 32'h1);
    wb_xfer(1'b1, 8'h08, 32'hff, 4'hf);
    wb_xfer(1'b0, 8'h08, 32'h0, 4'hf);
    check("unmapped read", rd, 32'h0);
    wb_xfer(1'b1, FLE_REG_CTRL, 32'h3, 4'he);
    repeat (3) @(posedge clk);
    check("masked write", 32'({aux_req, ds_seq, tr_allow}), 32'h1);
    $display("test reset done");
    // Coded link with compression, slow sink
    slow <= 1'b1;
    wb_xfer(1'b1, FLE_REG_CTRL, 32'h3, 4'h1);
    for (int t = 0; t < 10 && aux_req !== 1'b1; t++) @(posedge clk);
    check("announce addr", 32'(aux_addr), 32'(FLE_SINK_CFG_ADDR));
    check("announce data", 32'(aux_data), 32'(FLE_SINK_CFG_READY));
    check("early train", 32'({aux_req, tr_allow, tr_done, dsc_allow}), 32'h8);
    wait_state(5'h10);
    check("state enc", 32'(rd[4:0]), 32'h10);
    check("sink decoding", 32'(decoding), 32'h1);
    for (int t = 0; t < 20 && dsc_allow !== 1'b1; t++) @(posedge clk);
    check("dsc allowed", 32'(dsc_allow), 32'h1);
    stall_en <= 1'b1;
    send(500, 10'h100);
    check_stream(508, 1'b1);
    check("early parity", 32'(early_sym), 32'h0);
    stall_en <= 1'b0;
    $display("test coded done");
    // Compression alone, then plain pass-through
    wb_xfer(1'b1, FLE_REG_CTRL, 32'h2, 4'h1);
    wait_state(5'h01);
    check("dsc no fec", 32'({dsc_allow, rd[10]}), 32'h1);
    wb_xfer(1'b0, FLE_REG_CTRL, 32'h0, 4'hf);
    check("ctrl readback", rd, 32'h2);
    send(20, 10'h3f0);
    check_stream(20, 1'b0);
    $display("test plain done");
    // Transport, lane and self-refresh combinations
    foreach (modes[k]) begin
      slow <= k[0];
      wb_xfer(1'b1, FLE_REG_CTRL, 32'(modes[k]), 4'h1);
      wait_state(k == 6 ? 5'h01 : 5'h10);
      check("mode state", 32'({rd[9], rd[4:0]}), k == 6 ? 32'h21 : 32'h10);
      wb_xfer(1'b1, FLE_REG_CTRL, 32'h0, 4'h1);
    end
    $display("test modes done");
    give_verdict();
  end
endmodule : fle_fec_link_tb
`default_nettype wire
